/* File: verilog/shc_host_pins.sv */
// host-facing control pins: serial port, reset, interrupt, watchdog, CAN data
// Notes on behaviour
// - after power-up, undervoltage or a watchdog failure the reset output is held low 15 ms (3.5 ms short variant).
// - the interrupt output goes low only for a pending condition whose enable is set.
// - the serial data output is driven only while selected and released otherwise.
// - serial traffic is acted on only while the active-low select is low.
// - the watchdog output goes low when the watchdog is not served correctly.
// - in normal mode, transmit bits from the host go to the bus and the bus level comes back on the receive pin; both are recessive in the other modes.
// - the serial port works with any serial clock up to 4 MHz.
// - the CAN data path carries bit rates up to 1 Mbps.
// - normal, standby, stop and sleep modes are selected through the serial port.
`default_nettype none
module shc_host_pins
    import shc_pkg::*;
#(
    parameter bit SHORT_RESET      = 1'b0,
    parameter int RST_LONG_CYCLES  = RST_LONG_CYC,
    parameter int RST_SHORT_CYCLES = RST_SHORT_CYC,
    parameter int WD_CYCLES        = WD_TIMEOUT_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               sclk,
    input  wire logic               cs_n,
    input  wire logic               mosi,
    output var  logic               miso,
    output var  logic               miso_oe,
    input  wire logic               txd,
    output var  logic               rxd,
    output var  logic               can_tx,
    input  wire logic               can_rx,
    input  wire logic               vdd_uv,
    input  wire logic [NUM_IRQ-1:0] irq_event,
    output var  logic               rst_n,
    output var  logic               int_n,
    output var  logic               watchdog_fault_out_n,
    output var  logic [1:0]         mode_code
);
    localparam int WW = $clog2(WD_CYCLES + 1);

    typedef struct packed {
        logic                 sclk_s1, sclk_s2, sclk_d;
        logic                 cs_s1, cs_s2, cs_d;
        logic                 mosi_s1, mosi_s2;
        logic                 txd_s1, txd_s2;
        logic                 rx_s1, rx_s2;
        logic                 uv_s1, uv_s2;
        logic [FRAME_BITS-1:0] shift_in;
        logic [FRAME_BITS-1:0] shift_out;
        logic [2:0]           bitcnt;
        shc_mode_t            mode;
        logic [NUM_IRQ-1:0]   int_en;
        logic [NUM_IRQ-1:0]   flags;
        logic [WW-1:0]        wd_cnt;
        logic                 wd_fault;
        logic                 wd_trip;
        logic                 miso, miso_oe, int_n, wd_n, rxd, can_tx;
        logic [1:0]           mcode;
    } shc_state_t;

    shc_state_t s;
    shc_state_t next_s;
    logic       timer_rst_n;
    logic       timer_busy;
    logic       rst_n_q;

    // ************************************************************
    // mode code conversion
    // ************************************************************
    function automatic shc_mode_t mode_of(input logic [1:0] code);
        unique case (code)
            2'h0: mode_of = SHC_NORMAL;
            2'h1: mode_of = SHC_STANDBY;
            2'h2: mode_of = SHC_STOP;
            2'h3: mode_of = SHC_SLEEP;
        endcase
    endfunction

    function automatic logic [1:0] code_of(input shc_mode_t m);
        unique case (m)
            SHC_NORMAL:  code_of = 2'h0;
            SHC_STANDBY: code_of = 2'h1;
            SHC_STOP:    code_of = 2'h2;
            SHC_SLEEP:   code_of = 2'h3;
        endcase
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic                  rise;
        logic                  fall;
        logic                  sel;
        logic                  cs_fall;
        logic [FRAME_BITS-1:0] word;
        logic                  done;
        logic                  serve;
        logic                  bad;
        logic [NUM_IRQ-1:0]    clr;
        rise    = 1'b0;
        fall    = 1'b0;
        sel     = 1'b0;
        cs_fall = 1'b0;
        word    = '0;
        done    = 1'b0;
        serve   = 1'b0;
        bad     = 1'b0;
        clr     = '0;
        next_s  = s;
        // two-stage synchronisers for every pin input
        next_s.sclk_s1 = sclk;
        next_s.sclk_s2 = s.sclk_s1;
        next_s.sclk_d  = s.sclk_s2;
        next_s.cs_s1   = cs_n;
        next_s.cs_s2   = s.cs_s1;
        next_s.cs_d    = s.cs_s2;
        next_s.mosi_s1 = mosi;
        next_s.mosi_s2 = s.mosi_s1;
        next_s.txd_s1  = txd;
        next_s.txd_s2  = s.txd_s1;
        next_s.rx_s1   = can_rx;
        next_s.rx_s2   = s.rx_s1;
        next_s.uv_s1   = vdd_uv;
        next_s.uv_s2   = s.uv_s1;

        rise    = s.sclk_s2 & ~s.sclk_d;
        fall    = ~s.sclk_s2 & s.sclk_d;
        sel     = ~s.cs_s2;
        cs_fall = ~s.cs_s2 & s.cs_d;
        word    = {s.shift_in[FRAME_BITS-2:0], s.mosi_s2};

        // serial shifter: sample on rising edge, shift out on falling edge
        if (!sel) begin
            next_s.miso_oe = 1'b0;
            next_s.bitcnt  = '0;
        end else begin
            next_s.miso_oe = 1'b1;
            if (cs_fall) begin
                next_s.shift_out = '0;
                next_s.shift_out[MODE_ST_MSB:MODE_ST_LSB] = code_of(s.mode);
                next_s.shift_out[WDF_ST_BIT] = s.wd_fault;
                next_s.shift_out[NUM_IRQ-1:0] = s.flags;
                next_s.miso    = next_s.shift_out[FRAME_BITS-1];
                next_s.bitcnt  = '0;
            end else if (rise) begin
                next_s.shift_in = word;
                next_s.bitcnt   = s.bitcnt + 3'h1;
                done            = (s.bitcnt == 3'h7);
            end else if (fall) begin
                next_s.shift_out = {s.shift_out[FRAME_BITS-2:0], 1'b0};
                next_s.miso      = s.shift_out[FRAME_BITS-2];
            end
        end

        // command decode at the end of a full frame
        if (done) begin
            unique case (word[OP_MSB:OP_LSB])
                OP_MODE: next_s.mode   = mode_of(word[1:0]);
                OP_WATCHDOG_FAULT_OUT_N: begin
                    serve = (word[ARG_MSB:0] == WD_KEY);
                    bad   = ~serve;
                end
                OP_IEN:  next_s.int_en = word[NUM_IRQ-1:0];
                OP_STAT: clr           = s.flags;               // read clears the flags held at the end of the frame
            endcase
        end

        // sticky flags, a new event wins over the clear
        next_s.flags = (s.flags & ~clr) | irq_event;
        next_s.int_n = ~|(next_s.flags & next_s.int_en);

        // watchdog: counts outside reset, trips on timeout or wrong value
        next_s.wd_trip = 1'b0;
        if (timer_busy) begin
            next_s.wd_cnt = '0;
        end else if (serve) begin
            next_s.wd_cnt   = '0;
            next_s.wd_fault = 1'b0;
        end else if (bad || s.wd_cnt == WW'(WD_CYCLES - 1)) begin
            next_s.wd_cnt   = '0;
            next_s.wd_fault = 1'b1;
            next_s.wd_trip  = 1'b1;
        end else begin
            next_s.wd_cnt = s.wd_cnt + WW'(1);
        end
        next_s.wd_n = ~next_s.wd_fault;

        // a reset pulse puts the device back in normal mode
        if (timer_busy) begin
            next_s.mode = SHC_NORMAL;
        end

        // CAN data path is live in normal mode only, recessive elsewhere
        if (next_s.mode == SHC_NORMAL) begin
            next_s.can_tx = s.txd_s2;
            next_s.rxd    = s.rx_s2;
        end else begin
            next_s.can_tx = 1'b1;
            next_s.rxd    = 1'b1;
        end

        // mode code for observation, registered with the rest of the state
        next_s.mcode = code_of(next_s.mode);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s         <= '0;
            s.sclk_s1 <= 1'b0;
            s.cs_s1   <= 1'b1;
            s.cs_s2   <= 1'b1;
            s.cs_d    <= 1'b1;
            s.mode    <= SHC_NORMAL;
            s.int_en  <= IEN_RST;
            s.flags   <= FLAG_RST;
            s.int_n   <= 1'b1;
            s.wd_n    <= 1'b1;
            s.rxd     <= 1'b1;
            s.can_tx  <= 1'b1;
            s.miso    <= 1'b0;
            s.miso_oe <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // reset pulse timer
    // ************************************************************
    shc_reset_timer #(
        .HOLD_CYCLES (SHORT_RESET ? RST_SHORT_CYCLES : RST_LONG_CYCLES)
    ) u_rst_timer (
        .clk       (clk),
        .rst       (rst),
        .trigger   (s.wd_trip),
        .hold_uv   (s.uv_s2),
        .rst_n_out (timer_rst_n),
        .busy      (timer_busy)
    );

    assign mode_code            = s.mcode;
    assign rst_n_q              = timer_rst_n;
    assign rst_n                = rst_n_q;
    assign miso                 = s.miso;
    assign miso_oe              = s.miso_oe;
    assign int_n                = s.int_n;
    assign watchdog_fault_out_n = s.wd_n;
    assign rxd                  = s.rxd;
    assign can_tx               = s.can_tx;
endmodule
`default_nettype wire

/* File: verilog/shc_pkg.sv */
// shared constants and types for the host control pin block
`default_nettype none
package shc_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ          = 25_000_000;
    localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
    localparam int RST_LONG_US     = 15_000;     // standard reset pulse, 15 ms
    localparam int RST_SHORT_US    = 3_500;      // short variant reset pulse, 3.5 ms
    localparam int RST_LONG_CYC    = RST_LONG_US * CLK_PER_US;
    localparam int RST_SHORT_CYC   = RST_SHORT_US * CLK_PER_US;
    localparam int WD_TIMEOUT_US   = 100_000;    // watchdog service period
    localparam int WD_TIMEOUT_CYC  = WD_TIMEOUT_US * CLK_PER_US;
    localparam int SERIAL_MAX_HZ   = 4_000_000;  // highest serial clock supported
    localparam int CAN_MAX_BPS     = 1_000_000;  // highest CAN bit rate supported

    // ************************************************************
    // serial frame layout
    // ************************************************************
    localparam int FRAME_BITS      = 8;
    localparam int OP_MSB          = 7;
    localparam int OP_LSB          = 6;
    localparam int ARG_MSB         = 3;
    localparam int MODE_ST_MSB     = 7;          // mode field in status byte
    localparam int MODE_ST_LSB     = 6;
    localparam int WDF_ST_BIT      = 5;          // watchdog fault in status byte
    localparam logic [1:0] OP_MODE = 2'h0;
    localparam logic [1:0] OP_WATCHDOG_FAULT_OUT_N = 2'h1;
    localparam logic [1:0] OP_IEN  = 2'h2;
    localparam logic [1:0] OP_STAT = 2'h3;
    localparam logic [3:0] WD_KEY  = 4'hA;       // correct watchdog service value

    // ************************************************************
    // reset values and modes
    // ************************************************************
    localparam logic [3:0] IEN_RST  = 4'h0;
    localparam logic [3:0] FLAG_RST = 4'h0;
    localparam int NUM_IRQ          = 4;

    typedef enum logic [1:0] {
        SHC_NORMAL,
        SHC_STANDBY,
        SHC_STOP,
        SHC_SLEEP
    } shc_mode_t;
endpackage
`default_nettype wire

/* File: verilog/shc_reset_timer.sv */
// reset pulse timer driving the active-low reset output
`default_nettype none
module shc_reset_timer
    import shc_pkg::*;
#(
    parameter int HOLD_CYCLES = RST_LONG_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic trigger,
    input  wire logic hold_uv,
    output var  logic rst_n_out,
    output var  logic busy
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    typedef struct packed {
        logic          active;
        logic [CW-1:0] cnt;
        logic          rst_n_out;
    } shc_rt_state_t;

    shc_rt_state_t s;
    shc_rt_state_t next_s;

    // ************************************************************
    // pulse counting
    // ************************************************************
    // restart while undervoltage or on a trip, then count the hold time
    always_comb begin
        next_s = s;
        if (hold_uv || trigger) begin
            next_s.active = 1'b1;
            next_s.cnt    = '0;
        end else if (s.active) begin
            if (s.cnt == CW'(HOLD_CYCLES - 1)) begin
                next_s.active = 1'b0;
            end else begin
                next_s.cnt = s.cnt + CW'(1);
            end
        end
        next_s.rst_n_out = ~next_s.active;
    end

    // power-up starts with the pulse already running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{active: 1'b1, cnt: '0, rst_n_out: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign rst_n_out = s.rst_n_out;
    assign busy      = s.active;
endmodule
`default_nettype wire

/* File: tb/shc_host_pins_properties.sv */
// assertion checker for the host control pin block
`default_nettype none
module shc_host_pins_properties
    import shc_pkg::*;
#(
    parameter bit SHORT_RESET      = 1'b0,
    parameter int RST_LONG_CYCLES  = RST_LONG_CYC,
    parameter int RST_SHORT_CYCLES = RST_SHORT_CYC
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               cs_n,
    input wire logic               miso_oe,
    input wire logic               txd,
    input wire logic               rxd,
    input wire logic               can_tx,
    input wire logic               can_rx,
    input wire logic               vdd_uv,
    input wire logic [NUM_IRQ-1:0] irq_event,
    input wire logic               rst_n,
    input wire logic               int_n,
    input wire logic               watchdog_fault_out_n,
    input wire logic [1:0]         mode_code
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = SHORT_RESET ? RST_SHORT_CYCLES : RST_LONG_CYCLES;
    int low_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // counts cycles that the reset output has stayed low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= rst_n ? 0 : low_cnt + 1;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    chk_oe_idle: assert property (cs_n [*5] |-> !miso_oe)
        else $error("serial output driven while deselected");
    chk_oe_select: assert property (!cs_n [*5] |-> miso_oe)
        else $error("serial output not driven while selected");
    chk_int_cause: assert property ($fell(int_n) |-> $past(irq_event) != 4'h0 || !cs_n)
        else $error("interrupt output fell without a cause");
    chk_can_tx: assert property ((rst_n && mode_code == 2'h0) [*4] |-> can_tx == $past(txd, 3))
        else $error("transmit level does not follow the host");
    chk_can_rx: assert property ((rst_n && mode_code == 2'h0) [*4] |-> rxd == $past(can_rx, 3))
        else $error("receive pin does not follow the bus");
    chk_can_idle: assert property ((mode_code != 2'h0) [*2] |-> can_tx && rxd)
        else $error("CAN path live outside normal mode");
    chk_uv_hold: assert property (vdd_uv [*3] |=> !rst_n)
        else $error("reset output high during undervoltage");
    chk_rst_len: assert property ($rose(rst_n) |-> low_cnt >= HOLD - 1)
        else $error("reset pulse too short");
    chk_wd_reset: assert property ($fell(watchdog_fault_out_n) |-> ##[0:3] !rst_n)
        else $error("watchdog fault without reset pulse");
    chk_wd_release: assert property ($rose(watchdog_fault_out_n) |-> !cs_n)
        else $error("watchdog output released without service");
    cover property ($fell(int_n));
    cover property ($fell(watchdog_fault_out_n));
    cover property (mode_code == 2'h3 && !cs_n);
endmodule

bind shc_host_pins shc_host_pins_properties #(
    .SHORT_RESET(SHORT_RESET),
    .RST_LONG_CYCLES(RST_LONG_CYCLES),
    .RST_SHORT_CYCLES(RST_SHORT_CYCLES)
) chk_u (
    .clk, .rst, .cs_n, .miso_oe, .txd, .rxd, .can_tx, .can_rx, .vdd_uv, .irq_event,
    .rst_n, .int_n, .watchdog_fault_out_n, .mode_code
);
`default_nettype wire

/* File: tb/shc_host_model.sv */
// host controller model: serial master and CAN transmit source
`default_nettype none
module shc_host_model (
    input  wire logic clk,
    input  wire logic miso,
    input  wire logic miso_oe,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic mosi,
    output var  logic txd
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle levels: deselected, clock low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        txd  = 1'b1;
    end
    // one byte, msb first, 8 clk per serial bit; sel low leaves select high
    task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
        cs_n <= !sel;
        repeat (6) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            mosi <= tx[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            rx[i] = miso_oe ? miso : 1'bx;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~tx[0];
        repeat (6) @(posedge clk);
    endtask
    // next transmit bit toward the bus
    task automatic set_txd(input logic b);
        txd <= b;
    endtask
endmodule
`default_nettype wire

/* File: tb/shc_host_pins_tb.sv */
// self-checking testbench for the host control pin block
`default_nettype none
module shc_host_pins_tb
    import shc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int L  = 50;
    localparam int WD = 400;
    localparam int S  = 20;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        can_rx    = 1'b1;
    logic        vdd_uv    = 1'b0;
    logic [3:0]  irq_event = 4'h0;
    logic [31:0] lfsr      = 32'hA56DB37C;
    logic        sclk, cs_n, mosi, txd, miso, miso_oe, rxd, can_tx, rst_n, int_n, wdf_n, rst_n_s;
    logic [1:0]  mode_code;
    logic [7:0]  rx;
    int          mode_m, ien_m, flags_m, wdf_m, miscompares, check_count;
    always #20 clk = ~clk;
    shc_host_pins #(.RST_LONG_CYCLES(L), .RST_SHORT_CYCLES(S), .WD_CYCLES(WD)) dut_u (
        .clk, .rst, .sclk, .cs_n, .mosi, .miso, .miso_oe, .txd, .rxd, .can_tx, .can_rx,
        .vdd_uv, .irq_event, .rst_n, .int_n, .watchdog_fault_out_n(wdf_n), .mode_code);
    // short-variant copy on the same pins, watched here for its reset pulse
    shc_host_pins #(.SHORT_RESET(1'b1), .RST_LONG_CYCLES(L), .RST_SHORT_CYCLES(S),
        .WD_CYCLES(WD)) dut_s (
        .clk, .rst, .sclk, .cs_n, .mosi, .miso(), .miso_oe(), .txd, .rxd(), .can_tx(),
        .can_rx, .vdd_uv, .irq_event, .rst_n(rst_n_s), .int_n(), .watchdog_fault_out_n(),
        .mode_code());
    shc_host_model host_u (.clk, .miso, .miso_oe, .sclk, .cs_n, .mosi, .txd);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_rst(input int lo, input int hi, input bit short_v = 1'b0);
        int n;
        n = 0;
        while ((short_v ? rst_n_s : rst_n) !== 1'b1 && n < hi + 10) begin
            @(posedge clk);
            n++;
        end
        check("reset length ok", 8'h1, 8'(n >= lo && n <= hi));
        if (n >= hi + 10) begin
            test_done();
        end
    endtask
    task automatic cmp_all();
        check("mode", 8'(mode_m), {6'h0, mode_code});
        check("int_n", 8'(!(flags_m & ien_m)), {7'h0, int_n});
        check("watchdog out", 8'(!wdf_m), {7'h0, wdf_n});
    endtask
    // one serial command, model updated, outputs compared
    task automatic op(input logic [7:0] b);
        logic [7:0] st;
        st = {mode_m[1:0], wdf_m[0], 1'b0, flags_m[3:0]};
        host_u.xfer(b, 1'b1, rx);
        case (b[7:6])
            OP_MODE: mode_m = b[1:0];
            OP_IEN: ien_m = b[3:0];
            OP_WATCHDOG_FAULT_OUT_N: wdf_m = (b[3:0] != WD_KEY);
            default: begin
                check("status", st, rx);
                flags_m = 0;
            end
        endcase
        if (wdf_m != 0 && b[7:6] == OP_WATCHDOG_FAULT_OUT_N) begin
            mode_m = 0;
        end
        repeat (2) @(posedge clk);
        cmp_all();
    endtask
    task automatic can_chk();
        logic t, r;
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            t = lfsr[0];
            r = lfsr[5];
            host_u.set_txd(t);
            can_rx <= r;
            repeat (4) @(posedge clk);
            check("can_tx", 8'(mode_m == 0 ? t : 1'b1), {7'h0, can_tx});
            check("rxd", 8'(mode_m == 0 ? r : 1'b1), {7'h0, rxd});
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [3:0] ev;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        fork
            wait_rst(L - 1, L + 3);
            wait_rst(S - 1, S + 3, 1'b1);
        join
        for (int m = 0; m < 4; m++) begin
            op({OP_MODE, 4'h0, 2'(m)});
            can_chk();
            op({OP_STAT, 6'h0});
            op({OP_WATCHDOG_FAULT_OUT_N, 2'h0, WD_KEY});
        end
        host_u.xfer({OP_MODE, 6'h0}, 1'b0, rx);
        cmp_all();
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            ev = (k == 0) ? 4'hF : lfsr[7:4];
            op({OP_IEN, 2'h0, (k == 0) ? 4'h0 : lfsr[3:0]});
            irq_event <= ev;
            @(posedge clk);
            irq_event <= 4'h0;
            flags_m = flags_m | ev;
            repeat (3) @(posedge clk);
            cmp_all();
            op({OP_STAT, 6'h0});
            op({OP_WATCHDOG_FAULT_OUT_N, 2'h0, WD_KEY});
        end
        op({OP_WATCHDOG_FAULT_OUT_N, 2'h0, 4'h3});
        check("reset out", 8'h0, {7'h0, rst_n});
        wait_rst(1, L + 4);
        op({OP_WATCHDOG_FAULT_OUT_N, 2'h0, WD_KEY});
        op({OP_MODE, 6'h2});
        repeat (WD) @(posedge clk);
        mode_m = 0;
        wdf_m = 1;
        cmp_all();
        wait_rst(0, L + 4);
        op({OP_WATCHDOG_FAULT_OUT_N, 2'h0, WD_KEY});
        op({OP_MODE, 6'h1});
        vdd_uv <= 1'b1;
        repeat (20) @(posedge clk);
        check("reset out", 8'h0, {7'h0, rst_n});
        vdd_uv <= 1'b0;
        wait_rst(L, L + 5);
        mode_m = 0;
        op({OP_WATCHDOG_FAULT_OUT_N, 2'h0, WD_KEY});
        test_done();
    end
endmodule
`default_nettype wire
